// ### spo_pkg.sv
// Shared constants and types for the sampling PLL override and oscillator trim block
package spo_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_OVERRIDE = 8'h58;
   localparam logic [7:0] ADDR_TRIM = 8'h59;
   localparam logic [7:0] ADDR_HOLD = 8'h5c;
   localparam logic [7:0] ADDR_CAL_CTRL = 8'h5d;
   localparam logic [7:0] ADDR_CAL_STATUS = 8'h5e;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int OVR_SELECT_BIT = 7;
   localparam int SECOND_MODE_LSB = 4;
   localparam int FIRST_MODE_LSB = 2;
   localparam int SE_SELECT_BIT = 1;
   localparam int PLL_ENABLE_BIT = 0;
   localparam int TRIM_W = 7;
   localparam int HOLD_BIT = 0;
   localparam int CAL_SETTLE_LSB = 4;
   localparam int CAL_SETTLE_W = 3;
   localparam int CAL_ENABLE_BIT = 0;
   localparam int CAL_DONE_BIT = 0;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] OVERRIDE_RESET = 8'h00;
   localparam logic [6:0] TRIM_RESET = 7'h00;
   localparam logic HOLD_RESET = 1'b0;
   localparam logic [7:0] CAL_CTRL_RESET = 8'h40;

   // ------------------------------------------------------------
   // Divided-reference output modes
   // ------------------------------------------------------------
   localparam logic [1:0] REFOUT_OFF = 2'h0;
   localparam logic [1:0] REFOUT_DIV1 = 2'h1;
   localparam logic [1:0] REFOUT_DIV2 = 2'h2;
   localparam logic [1:0] REFOUT_DIV4 = 2'h3;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int SETTLE_UNIT_NS = 3200;
   // Least time, so round up
   localparam int SETTLE_UNIT_CYCLES = (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] second_refout_mode;
      logic [1:0] first_refout_mode;
      logic single_ended_ref_select;
      logic pll_enable_value;
   } spo_pll_cfg_t;

   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_SETTLE = 2'b01,
      CAL_DECIDE = 2'b10
   } spo_cal_state_t;

endpackage

// ### spo_pll_override.sv
// Sampling PLL pin override, divided-reference outputs, hold bit and oscillator trim calibration
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Override select 0 makes pins drive PLL controls; 1 makes register fields drive them.
// - Bits 5:4 set the second reference output only under override; else pins.
// - Bits 3:2 set the first reference output only under override; else pins.
// - Output mode codes: 0 off, 1 divide by 1, 2 by 2, 3 by 4.
// - Second reference output stays quiet unless the first one is producing a clock.
// - Under override, bit 1 high selects single-ended reference input, low differential.
// - Under override, bit 0 high enables the PLL, low keeps it disabled.
// - Oscillator trim is seven bits, written automatically by the calibration engine.
// - Trim value reads back after calibration and may be written back later.
// - Clearing the hold bit with calibration enabled starts trim calibration.
// - Done reads 1 after calibration finishes, or at once on hold release when calibration disabled.
// - Settle field sets the wait after every trim step to field plus one settle units.
module spo_pll_override
   import spo_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_UNIT_CYCLES
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Register port, parallel side of the serial interface
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Configuration pins
   input wire logic pll_enable_pin,
   input wire logic ref_type_pin,
   input wire logic clock_config_pin_a,
   input wire logic clock_config_pin_b,
   // Analog side
   input wire logic ref_clk_level,
   input wire logic osc_above_target,
   // PLL controls
   output logic pll_enable,
   output logic single_ended_ref_select,
   output logic pll_hold,
   output logic [TRIM_W-1:0] oscillator_trim,
   output logic calibration_done,
   output logic calibration_busy,
   // Divided-reference outputs
   output logic first_refout,
   output logic second_refout
);

   localparam int SETTLE_CW = $clog2(8 * SETTLE_CYCLES + 1);

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic override_select;
   spo_pll_cfg_t ovr_fields;
   spo_pll_cfg_t cfg;
   logic pll_config_hold;
   logic hold_prev;
   logic [CAL_SETTLE_W-1:0] calibration_settle;
   logic calibration_enable;
   spo_cal_state_t state;
   spo_cal_state_t next_state;
   logic [2:0] bit_idx;
   logic [SETTLE_CW-1:0] settle_cnt;
   logic [TRIM_W-1:0] next_trim;
   logic [1:0] refout_q;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire wr_override = reg_write && (reg_addr == ADDR_OVERRIDE);
   wire wr_trim = reg_write && (reg_addr == ADDR_TRIM);
   wire wr_hold = reg_write && (reg_addr == ADDR_HOLD);
   wire wr_cal_ctrl = reg_write && (reg_addr == ADDR_CAL_CTRL);
   wire hold_release = hold_prev && !pll_config_hold;
   wire cal_idle = (state == CAL_IDLE);
   wire [SETTLE_CW-1:0] settle_len =
      SETTLE_CW'((32'(calibration_settle) + 1) * SETTLE_CYCLES);

   // ------------------------------------------------------------
   // Pin or register source for PLL controls
   // ------------------------------------------------------------
   // Pin mode drives both outputs from the same two strap pins
   wire [1:0] pin_refout_mode = {clock_config_pin_b, clock_config_pin_a};
   spo_pll_cfg_t pin_cfg;
   assign pin_cfg = '{second_refout_mode: pin_refout_mode,
                      first_refout_mode: pin_refout_mode,
                      single_ended_ref_select: ref_type_pin,
                      pll_enable_value: pll_enable_pin};
   // Registered selection lands one cycle after the select bit sets
   wire spo_pll_cfg_t next_cfg = override_select ? ovr_fields : pin_cfg;

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   wire [7:0] rd_override = {override_select, 1'b0, ovr_fields.second_refout_mode,
                             ovr_fields.first_refout_mode, ovr_fields.single_ended_ref_select,
                             ovr_fields.pll_enable_value};
   wire [7:0] rd_cal_ctrl = {1'b0, calibration_settle, 3'h0, calibration_enable};
   wire [7:0] read_mux =
      (reg_addr == ADDR_OVERRIDE) ? rd_override :
      (reg_addr == ADDR_TRIM) ? {1'b0, oscillator_trim} :
      (reg_addr == ADDR_HOLD) ? {7'h00, pll_config_hold} :
      (reg_addr == ADDR_CAL_CTRL) ? rd_cal_ctrl :
      (reg_addr == ADDR_CAL_STATUS) ? {7'h00, calibration_done} : 8'h00;

   // ------------------------------------------------------------
   // Calibration engine: successive approximation, MSB first
   // ------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_trim = oscillator_trim;
      if (pll_config_hold)
      begin
         next_state = CAL_IDLE;
         // A held, stopped engine is idle too, so a restored trim lands before release
         if (cal_idle && wr_trim)
            next_trim = reg_wdata[TRIM_W-1:0];
      end
      else
      begin
         case (state)
            CAL_IDLE:
            begin
               if (hold_release && calibration_enable)
               begin
                  next_state = CAL_SETTLE;
                  next_trim = 7'h40;
               end
               else if (wr_trim)
                  next_trim = reg_wdata[TRIM_W-1:0];
            end
            CAL_SETTLE:
            begin
               if (settle_cnt == SETTLE_CW'(1))
                  next_state = CAL_DECIDE;
            end
            CAL_DECIDE:
            begin
               // Trim writes are dropped here: they would corrupt the search
               if (osc_above_target)
                  next_trim[bit_idx] = 1'b0;
               if (bit_idx == 3'h0)
                  next_state = CAL_IDLE;
               else
               begin
                  next_trim[bit_idx - 3'h1] = 1'b1;
                  next_state = CAL_SETTLE;
               end
            end
            default:
               next_state = CAL_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         state <= CAL_IDLE;
         bit_idx <= 3'h0;
         settle_cnt <= '0;
         oscillator_trim <= TRIM_RESET;
         calibration_done <= 1'b0;
      end
      else
      begin
         state <= next_state;
         oscillator_trim <= next_trim;
         if (next_state == CAL_SETTLE && state != CAL_SETTLE)
            settle_cnt <= settle_len;
         else if (state == CAL_SETTLE)
            settle_cnt <= settle_cnt - SETTLE_CW'(1);
         if (cal_idle)
            bit_idx <= 3'h6;
         else if (state == CAL_DECIDE)
            bit_idx <= bit_idx - 3'h1;
         if (pll_config_hold)
            calibration_done <= 1'b0;
         else if (hold_release && !calibration_enable)
            calibration_done <= 1'b1;
         else if (state == CAL_DECIDE && next_state == CAL_IDLE)
            calibration_done <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         override_select <= OVERRIDE_RESET[OVR_SELECT_BIT];
         ovr_fields <= OVERRIDE_RESET[5:0];
         pll_config_hold <= HOLD_RESET;
         hold_prev <= HOLD_RESET;
         calibration_settle <= CAL_CTRL_RESET[CAL_SETTLE_LSB +: CAL_SETTLE_W];
         calibration_enable <= CAL_CTRL_RESET[CAL_ENABLE_BIT];
      end
      else
      begin
         hold_prev <= pll_config_hold;
         if (wr_override)
         begin
            override_select <= reg_wdata[OVR_SELECT_BIT];
            ovr_fields.second_refout_mode <= reg_wdata[SECOND_MODE_LSB +: 2];
            ovr_fields.first_refout_mode <= reg_wdata[FIRST_MODE_LSB +: 2];
            ovr_fields.single_ended_ref_select <= reg_wdata[SE_SELECT_BIT];
            ovr_fields.pll_enable_value <= reg_wdata[PLL_ENABLE_BIT];
         end
         if (wr_hold)
            pll_config_hold <= reg_wdata[HOLD_BIT];
         if (wr_cal_ctrl)
         begin
            calibration_settle <= reg_wdata[CAL_SETTLE_LSB +: CAL_SETTLE_W];
            calibration_enable <= reg_wdata[CAL_ENABLE_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         cfg <= '0;
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
         pll_enable <= 1'b0;
         single_ended_ref_select <= 1'b0;
         pll_hold <= HOLD_RESET;
         calibration_busy <= 1'b0;
      end
      else
      begin
         cfg <= next_cfg;
         reg_rvalid <= reg_read;
         if (reg_read)
            reg_rdata <= read_mux;
         pll_enable <= cfg.pll_enable_value;
         single_ended_ref_select <= cfg.single_ended_ref_select;
         pll_hold <= pll_config_hold;
         calibration_busy <= !cal_idle;
      end
   end

   // ------------------------------------------------------------
   // Divided-reference outputs
   // ------------------------------------------------------------
   wire [1:0] refout_mode [2];
   wire [1:0] refout_allow;
   assign refout_mode[0] = cfg.first_refout_mode;
   assign refout_mode[1] = cfg.second_refout_mode;
   assign refout_allow[0] = 1'b1;
   // Gated on the first output's mode so the two stay phase-related
   assign refout_allow[1] = (cfg.first_refout_mode != REFOUT_OFF);

   generate
      for (genvar gi = 0; gi < 2; gi++)
      begin : g_refout
         spo_refout_div u_div (
            .mclk(mclk),
            .srst(srst),
            .ref_level(ref_clk_level),
            .mode(refout_mode[gi]),
            .allow(refout_allow[gi]),
            .clk_out(refout_q[gi])
         );
      end
   endgenerate

   assign first_refout = refout_q[0];
   assign second_refout = refout_q[1];

endmodule // spo_pll_override

`default_nettype wire

// ### spo_pll_override_sva.sv
// Concurrent checks on the PLL override block ports
`timescale 1ns/10ps
`default_nettype none
module spo_pll_override_chk
   import spo_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Register port
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   // Pins and controls
   input wire logic pll_enable_pin,
   input wire logic pll_enable,
   input wire logic single_ended_ref_select,
   input wire logic pll_hold,
   input wire logic [TRIM_W-1:0] oscillator_trim,
   input wire logic calibration_done,
   input wire logic calibration_busy
);
   wire logic ovr_wr = reg_write && reg_addr == ADDR_OVERRIDE;
   wire logic mapped = reg_addr inside {ADDR_OVERRIDE, ADDR_TRIM, ADDR_HOLD, ADDR_CAL_CTRL,
      ADDR_CAL_STATUS};
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   a_read_answer: assert property (reg_read |=> reg_rvalid)
      else $error("read not answered");
   a_unmapped_zero: assert property (reg_read && !mapped |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_trim_readback: assert property (reg_read && reg_addr == ADDR_TRIM |=>
      reg_rdata == {1'b0, $past(oscillator_trim)}) else $error("trim read wrong");
   a_status_read: assert property (reg_read && reg_addr == ADDR_CAL_STATUS |=>
      reg_rdata == {7'h00, $past(calibration_done)}) else $error("status read wrong");
   a_hold_write: assert property (reg_write && reg_addr == ADDR_HOLD |-> ##2
      pll_hold == $past(reg_wdata[0], 2)) else $error("hold bit not stored");
   a_held_not_busy: assert property (pll_hold [*2] |-> !calibration_busy)
      else $error("engine busy while held");
   a_hold_clears_done: assert property (pll_hold [*3] |-> !calibration_done)
      else $error("done set while held");
   a_trim_idle_load: assert property (reg_write && reg_addr == ADDR_TRIM &&
      calibration_done && !calibration_busy |=> oscillator_trim == $past(reg_wdata[6:0]))
      else $error("idle trim write not loaded");
   a_override_regs: assert property (ovr_wr && reg_wdata[7] ##1 !ovr_wr [*2] |=>
      pll_enable == $past(reg_wdata[0], 3) && single_ended_ref_select == $past(reg_wdata[1], 3))
      else $error("override fields not applied");
   a_override_pins: assert property (ovr_wr && !reg_wdata[7] ##1
      (!ovr_wr && $stable(pll_enable_pin)) [*4] |=> pll_enable == $past(pll_enable_pin))
      else $error("pin mode not followed");
endmodule // spo_pll_override_chk
`default_nettype wire

// ### spo_refout_div.sv
// One divided-reference clock output: off, or reference divided by 1, 2 or 4
`timescale 1ns/10ps
`default_nettype none

module spo_refout_div
   import spo_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Reference and control
   input wire logic ref_level,
   input wire logic [1:0] mode,
   input wire logic allow,
   // Output
   output logic clk_out
);

   logic ref_prev;
   logic div_cnt;
   logic next_out;
   wire ref_rise = ref_level & ~ref_prev;
   wire active = allow && (mode != REFOUT_OFF);

   // ------------------------------------------------------------
   // Divider
   // ------------------------------------------------------------
   always_comb
   begin
      next_out = clk_out;
      if (!active)
         next_out = 1'b0;
      else if (mode == REFOUT_DIV1)
         next_out = ref_level;
      else if (ref_rise && (mode == REFOUT_DIV2 || div_cnt))
         next_out = ~clk_out;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         ref_prev <= 1'b0;
         div_cnt <= 1'b0;
         clk_out <= 1'b0;
      end
      else
      begin
         ref_prev <= ref_level;
         div_cnt <= active && (mode == REFOUT_DIV4) ? div_cnt ^ ref_rise : 1'b0;
         clk_out <= next_out;
      end
   end

endmodule // spo_refout_div

`default_nettype wire

// ### tb.sv
// Self-checking bench for the PLL override and oscillator trim block
`timescale 1ns/10ps
`default_nettype none
module tb;
   import spo_pkg::*;
   localparam int SC = 2;
   logic mclk = 0, srst = 1, reg_write = 0, reg_read = 0, pll_enable_pin = 0, ref_type_pin = 0;
   logic clock_config_pin_a = 0, clock_config_pin_b = 0, ref_clk_level = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val, n1, n2;
   logic reg_rvalid, pll_enable, single_ended_ref_select, pll_hold;
   logic calibration_done, calibration_busy, first_refout, second_refout;
   logic [6:0] oscillator_trim;
   wire logic osc_above_target;
   int err_count = 0, comparisons = 0, ref_cnt = 0, d0, d1;
   // Comparator model: oscillator too fast above a fixed trim
   assign osc_above_target = oscillator_trim > 7'h2b;
   always #25 mclk = ~mclk;
   // Reference slower than mclk/2, period of eight cycles
   always @(negedge mclk)
   begin
      ref_cnt <= ref_cnt + 1;
      if (ref_cnt % 4 == 3)
         ref_clk_level <= ~ref_clk_level;
   end
   spo_pll_override #(.SETTLE_CYCLES(SC)) i_spo_pll_override (.mclk, .srst, .reg_write,
      .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .pll_enable_pin, .ref_type_pin,
      .clock_config_pin_a, .clock_config_pin_b, .ref_clk_level, .osc_above_target, .pll_enable,
      .single_ended_ref_select, .pll_hold, .oscillator_trim, .calibration_done,
      .calibration_busy, .first_refout, .second_refout);
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_write = 1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_write = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk);
      reg_read = 1;
      reg_addr = a;
      @(negedge mclk);
      reg_read = 0;
      rd_val = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
      chk(rd_val, exp);
   endtask
   // Edge counts over a whole number of divided periods do not depend on phase
   task automatic cnt(input logic [7:0] e1, input logic [7:0] e2);
      logic p1, p2;
      n1 = 0;
      n2 = 0;
      repeat (24) @(negedge mclk);
      repeat (64)
      begin
         p1 = first_refout;
         p2 = second_refout;
         @(negedge mclk);
         n1 += 8'(first_refout !== p1);
         n2 += 8'(second_refout !== p2);
      end
      chk(n1, e1);
      chk(n2, e2);
   endtask
   task automatic cal(input logic [7:0] ctrl, output int dur);
      wr(ADDR_HOLD, 8'h01);
      wr(ADDR_CAL_CTRL, ctrl);
      wr(ADDR_HOLD, 8'h00);
      repeat (2) @(negedge mclk);
      chk({7'h00, calibration_busy}, {7'h00, ctrl[0]});
      dur = 0;
      while (calibration_done !== 1'b1)
      begin
         @(negedge mclk);
         dur++;
         if (dur > 3000)
         begin
            err_count++;
            $display("mismatch at %0t: calibration wait timed out", $time);
            stop_test();
         end
      end
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (5) @(negedge mclk);
      srst = 0;
      rd(ADDR_OVERRIDE, 8'h00);
      rd(ADDR_TRIM, 8'h00);
      rd(ADDR_HOLD, 8'h00);
      rd(ADDR_CAL_CTRL, 8'h40);
      rd(ADDR_CAL_STATUS, 8'h00);
      rd(8'h5a, 8'h00);
      pll_enable_pin = 1;
      ref_type_pin = 1;
      clock_config_pin_b = 1;
      cnt(8'h08, 8'h08);
      chk({6'h00, pll_enable, single_ended_ref_select}, 8'h03);
      wr(ADDR_OVERRIDE, 8'h03);
      repeat (5) @(negedge mclk);
      pll_enable_pin = 0;
      ref_type_pin = 0;
      repeat (4) @(negedge mclk);
      chk({6'h00, pll_enable, single_ended_ref_select}, 8'h00);
      rd(ADDR_OVERRIDE, 8'h03);
      wr(ADDR_OVERRIDE, 8'h83);
      repeat (3) @(negedge mclk);
      chk({6'h00, pll_enable, single_ended_ref_select}, 8'h03);
      wr(ADDR_OVERRIDE, 8'h82);
      repeat (3) @(negedge mclk);
      chk({6'h00, pll_enable, single_ended_ref_select}, 8'h01);
      for (int m = 0; m < 4; m++)
      begin
         wr(ADDR_OVERRIDE, 8'h90 | 8'(m << 2));
         cnt(m == 0 ? 8'h00 : 8'h20 >> m, m == 0 ? 8'h00 : 8'h10);
         wr(ADDR_OVERRIDE, 8'h84 | 8'(m << 4));
         cnt(8'h10, m == 0 ? 8'h00 : 8'h20 >> m);
      end
      cal(8'h01, d0);
      rd(ADDR_TRIM, 8'h2b);
      rd(ADDR_CAL_STATUS, 8'h01);
      cal(8'h11, d1);
      chk(8'(d1 - d0), 8'(7 * SC));
      wr(ADDR_TRIM, 8'h15);
      chk({1'b0, oscillator_trim}, 8'h15);
      rd(ADDR_TRIM, 8'h15);
      cal(8'h40, d0);
      chk(8'(d0 < 4), 8'h01);
      chk({1'b0, oscillator_trim}, 8'h15);
      wr(ADDR_HOLD, 8'h01);
      wr(ADDR_TRIM, 8'h2b);
      chk({1'b0, oscillator_trim}, 8'h2b);
      stop_test();
   end
endmodule // tb
bind spo_pll_override spo_pll_override_chk i_spo_pll_override_chk (.mclk, .srst, .reg_write,
   .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .pll_enable_pin, .pll_enable,
   .single_ended_ref_select, .pll_hold, .oscillator_trim, .calibration_done, .calibration_busy);
`default_nettype wire
